// File: hfd_decoder.sv
// High-band spectral and gain parameter decoder with its output FIFO
`default_nettype none

module hfd_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         arst_n,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_q [DEPTH];
    logic [AW:0]  wr_q;
    logic [AW:0]  rd_q;
    logic         full;
    logic         empty;

    assign full      = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    assign empty     = (wr_q == rd_q);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem_q[rd_q[AW-1:0]];

    always_ff @(posedge clk) begin
        if (in_valid && !full) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (in_valid && !full) begin
                wr_q <= wr_q + 1'b1;
            end
            if (out_ready && !empty) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule

// How it works
// - Frames are tracked by quarter position inside a 1024-sample superframe so they line up with low-band frames.
// - A frame-size entry of one or less means 256 samples, two means 512 and three means 1024.
// - One gain value in dB is issued for every 64-sample subframe to scale the low-band excitation.
// - The issued parameters feed downstream buzz reduction and an order-8 synthesis filter.
// - The spectral loss flag is the loss bit of the frame's packet, its first packet, or bit 0 for long frames.
// - Spectral indices always arrive with the first packet that describes a frame.
// - The gain loss vector holds one, two or all four loss bits for short, medium and long frames.
// - Short, medium and long frames have 4, 8 and 16 interpolation subframes.
// - Without loss each entry is stage-one plus stage-two codevector plus mean plus half the predictor memory.
// - With loss each entry is 0.9 times the predictor memory plus the mean.
// - After decoding, entries are pushed up so neighbours keep at least the minimum spacing.
// - Reset clears the predictor memory to zero.
// - Subframe i of nb gets i/nb of the new spectral pairs plus the rest of the previous set.
// - Subframe i of nb gets i/nb of the matching gain plus the rest of its previous value.
module hfd_decoder
    import hfd_pkg::*;
#(
    parameter logic [4*ORDER*DW-1:0]   CB1   = '0,
    parameter logic [128*ORDER*DW-1:0] CB2   = '0,
    parameter logic [ORDER*DW-1:0]     MEAN  = hfd_mean_default(),
    parameter int                      DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        ARST_N,
    // Register port
    input  wire logic [3:0]  REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic [31:0]      REG_RDATA,
    // Frame parameters from the demultiplexer
    input  wire logic        FRAME_VALID,
    output logic             FRAME_READY,
    input  wire hfd_frame_t  FRAME,
    // Per-subframe parameters out
    output logic             SUB_VALID,
    input  wire logic        SUB_READY,
    output hfd_sub_t         SUB
);
    localparam int SW = $bits(hfd_sub_t);

    hfd_state_t          state_q;
    hfd_frame_t          frame_q;
    logic [1:0]          pos_q;
    logic                spec_loss_q;
    logic [3:0]          gain_loss_q;
    logic [4:0]          nb_q;
    logic [2:0]          shift_q;
    logic [10:0]         frame_len_q;
    logic [2:0]          j_q;
    logic [3:0]          sub_q;
    logic signed [DW-1:0] mem_q [ORDER];
    logic signed [DW-1:0] new_q [ORDER];
    logic signed [DW-1:0] old_q [ORDER];
    logic signed [DW-1:0] old_g_q;
    logic                en_q;
    logic                clr_mem_q;
    logic                align_err_q;
    logic [15:0]         frames_q;
    logic [31:0]         rdata_q;
    logic                accept;
    logic                push;
    logic                fifo_ready;
    logic                misalign;
    logic [2:0]          quarters;
    hfd_sub_t            word;
    logic signed [DW-1:0] dec_val;
    logic signed [DW-1:0] mean_j;
    logic signed [DW-1:0] reo_val;

    function automatic logic signed [DW-1:0] sat(input logic signed [23:0] v);
        if (v > 24'sd32767) begin
            return 16'sh7fff;
        end else if (v < -24'sd32768) begin
            return 16'sh8000;
        end
        return v[DW-1:0];
    endfunction

    assign accept = FRAME_VALID && FRAME_READY;
    assign FRAME_READY = (state_q == ST_IDLE) && en_q;
    assign push = (state_q == ST_INTERP) && fifo_ready;
    assign mean_j = $signed(MEAN[int'(j_q)*DW +: DW]);

    // Frame size and alignment within the superframe
    always_comb begin
        if (FRAME.mode == MODE_LONG) begin
            quarters = 3'd4;
        end else if (FRAME.mode == MODE_MEDIUM) begin
            quarters = 3'd2;
        end else begin
            quarters = 3'd1;
        end
        misalign = ((FRAME.mode == MODE_LONG) && (pos_q != 2'd0)) ||
                   ((FRAME.mode == MODE_MEDIUM) && pos_q[0]);
    end

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            pos_q <= '0;
        end else if (accept) begin
            pos_q <= 2'((3'(pos_q) + quarters) % 3'(QUARTERS));
        end
    end

    // Loss controls, subframe count and frame length taken with the frame
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            frame_q     <= '0;
            spec_loss_q <= 1'b0;
            gain_loss_q <= '0;
            nb_q        <= 5'(NB_SHORT);
            shift_q     <= 3'd2;
            frame_len_q <= 11'(LEN_SHORT);
        end else if (accept) begin
            frame_q <= FRAME;
            if (FRAME.mode == MODE_LONG) begin
                spec_loss_q <= FRAME.loss[0];
                gain_loss_q <= FRAME.loss;
                nb_q        <= 5'(NB_LONG);
                shift_q     <= 3'd4;
                frame_len_q <= 11'(LEN_LONG);
            end else if (FRAME.mode == MODE_MEDIUM) begin
                spec_loss_q <= FRAME.loss[pos_q];
                gain_loss_q <= {2'b00, FRAME.loss[pos_q], FRAME.loss[2'(pos_q + 2'd1)]};
                nb_q        <= 5'(NB_MEDIUM);
                shift_q     <= 3'd3;
                frame_len_q <= 11'(LEN_MEDIUM);
            end else begin
                spec_loss_q <= FRAME.loss[pos_q];
                gain_loss_q <= {3'b000, FRAME.loss[pos_q]};
                nb_q        <= 5'(NB_SHORT);
                shift_q     <= 3'd2;
                frame_len_q <= 11'(LEN_SHORT);
            end
        end
    end

    // Sequencer: decode, reorder, interpolate, retire
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_q <= ST_IDLE;
            j_q     <= '0;
            sub_q   <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    j_q   <= '0;
                    sub_q <= '0;
                    if (accept) begin
                        state_q <= ST_DECODE;
                    end
                end
                ST_DECODE: begin
                    j_q <= j_q + 3'd1;
                    if (j_q == 3'(ORDER - 1)) begin
                        state_q <= ST_REORDER;
                    end
                end
                ST_REORDER: begin
                    j_q <= j_q + 3'd1;
                    if (j_q == 3'(ORDER - 1)) begin
                        state_q <= ST_INTERP;
                    end
                end
                ST_INTERP: begin
                    if (push) begin
                        sub_q <= sub_q + 4'd1;
                        if (5'(sub_q) == nb_q - 5'd1) begin
                            state_q <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Predictive two-stage decode of one entry per cycle
    always_comb begin
        logic signed [DW-1:0] c1;
        logic signed [DW-1:0] c2;
        logic signed [35:0]   prod;
        logic signed [23:0]   sum;
        sum  = '0;
        c1   = $signed(CB1[(int'(frame_q.idx1) * ORDER + int'(j_q)) * DW +: DW]);
        c2   = $signed(CB2[(int'(frame_q.idx2) * ORDER + int'(j_q)) * DW +: DW]);
        prod = mem_q[j_q] * DECAY_Q;
        if (spec_loss_q) begin
            sum = 24'(prod >>> DECAY_FRAC) + 24'(mean_j);
        end else begin
            sum = 24'(c1) + 24'(c2) + 24'(mean_j) + 24'(mem_q[j_q] >>> MU_SHIFT);
        end
        dec_val = sat(sum);
    end

    // Minimum spacing; each entry sees its already corrected neighbour
    always_comb begin
        logic signed [23:0] lim;
        lim = 24'(ISF_GAP);
        if (j_q != 3'd0) begin
            lim = 24'(new_q[3'(j_q - 3'd1)]) + 24'(ISF_GAP);
        end
        reo_val = (24'(new_q[j_q]) < lim) ? sat(lim) : new_q[j_q];
    end

    always_ff @(posedge CLOCK) begin
        if (state_q == ST_DECODE) begin
            new_q[j_q] <= dec_val;
        end else if (state_q == ST_REORDER) begin
            new_q[j_q] <= reo_val;
        end
    end

    // Memory is taken from the raw decode so reordering never feeds back
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            for (int e = 0; e < ORDER; e++) begin
                mem_q[e] <= '0;
            end
        end else if (clr_mem_q) begin
            for (int e = 0; e < ORDER; e++) begin
                mem_q[e] <= '0;
            end
        end else if (state_q == ST_DECODE) begin
            mem_q[j_q] <= sat(24'(dec_val) - 24'(mean_j));
        end
    end

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            for (int e = 0; e < ORDER; e++) begin
                old_q[e] <= '0;
            end
            old_g_q <= '0;
        end else if (state_q == ST_DONE) begin
            for (int e = 0; e < ORDER; e++) begin
                old_q[e] <= new_q[e];
            end
            old_g_q <= frame_q.gmatch;
        end
    end

    // Linear interpolation, nb is a power of two so i/nb is a shift
    always_comb begin
        logic signed [23:0] d;
        d              = '0;
        word           = '0;
        word.sub       = sub_q;
        word.last      = (5'(sub_q) == nb_q - 5'd1);
        word.spec_loss = spec_loss_q;
        word.gain_loss = gain_loss_q;
        for (int e = 0; e < ORDER; e++) begin
            d = (24'(new_q[e]) - 24'(old_q[e])) * $signed({20'h0, sub_q});
            word.isp[e*DW +: DW] = sat(24'(old_q[e]) + (d >>> shift_q));
        end
        d = (24'(frame_q.gmatch) - 24'(old_g_q)) * $signed({20'h0, sub_q});
        word.gain_db = sat(24'(old_g_q) + (d >>> shift_q));
    end

    // The FIFO stalls interpolation when the synthesis side falls behind
    hfd_fifo #(
        .W     (SW),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (CLOCK),
        .arst_n    (ARST_N),
        .in_valid  (state_q == ST_INTERP),
        .in_ready  (fifo_ready),
        .in_data   (word),
        .out_valid (SUB_VALID),
        .out_ready (SUB_READY),
        .out_data  (SUB)
    );

    // Register port
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            en_q        <= CTRL_EN_RST;
            clr_mem_q   <= 1'b0;
            align_err_q <= 1'b0;
            frames_q    <= '0;
        end else begin
            clr_mem_q <= REG_WR && (REG_ADDR == REG_CTRL) && REG_WDATA[CTRL_CLRM_BIT];
            if (REG_WR && (REG_ADDR == REG_CTRL)) begin
                en_q <= REG_WDATA[CTRL_EN_BIT];
            end
            if (accept && misalign) begin
                align_err_q <= 1'b1;
            end else if (REG_WR && (REG_ADDR == REG_CTRL) && REG_WDATA[CTRL_CLRA_BIT]) begin
                align_err_q <= 1'b0;
            end
            if (state_q == ST_DONE) begin
                frames_q <= frames_q + 16'd1;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            rdata_q <= '0;
        end else if (REG_RD) begin
            case (REG_ADDR)
                REG_CTRL:   rdata_q <= {31'h0, en_q};
                REG_STATUS: rdata_q <= {5'h0, frame_len_q, nb_q, gain_loss_q, spec_loss_q, align_err_q,
                                        pos_q, state_q};
                REG_COUNT:  rdata_q <= {16'h0, frames_q};
                default:    rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end
    assign REG_RDATA = rdata_q;

    // Checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!ARST_N);

    logic [4:0] push_cnt_q;
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            push_cnt_q <= '0;
        end else if (state_q == ST_IDLE) begin
            push_cnt_q <= '0;
        end else if (push) begin
            push_cnt_q <= push_cnt_q + 5'd1;
        end
    end

    long_loss_a: assert property ((accept && FRAME.mode == MODE_LONG) |=>
        spec_loss_q == $past(FRAME.loss[0]) && gain_loss_q == $past(FRAME.loss)) else $error("long frame loss");
    short_gain_a: assert property ((accept && FRAME.mode <= 2'h1) |=>
        gain_loss_q[3:1] == 3'b000 && nb_q == 5'd4 && frame_len_q == 11'd256) else $error("short frame setup");
    medium_count_a: assert property ((accept && FRAME.mode == MODE_MEDIUM) |=>
        nb_q == 5'd8 && frame_len_q == 11'd512) else $error("medium frame setup");
    decode_span_a: assert property ($rose(state_q == ST_DECODE) |->
        (state_q == ST_DECODE)[*8] ##1 (state_q == ST_REORDER)[*8] ##1 state_q == ST_INTERP) else $error("decode span");
    decay_loss_a: assert property ((state_q == ST_DECODE && spec_loss_q && mem_q[j_q] == 16'sh0) |=>
        new_q[$past(j_q)] == $past(mean_j)) else $error("loss decay");
    mem_update_a: assert property ((state_q == ST_DECODE) |=>
        mem_q[$past(j_q)] == sat(24'($past(dec_val)) - 24'($past(mean_j)))) else $error("memory update");
    mem_clear_a: assert property (clr_mem_q |=> mem_q[0] == 16'sh0 && mem_q[ORDER-1] == 16'sh0)
        else $error("memory clear");
    gap_kept_a: assert property ((state_q == ST_INTERP && new_q[6] < 16'sh7000) |->
        24'(new_q[0]) >= 24'(ISF_GAP) && 24'(new_q[1]) - 24'(new_q[0]) >= 24'(ISF_GAP)) else $error("spacing");
    first_sub_a: assert property ((push && sub_q == 4'd0) |->
        word.isp[DW-1:0] == old_q[0] && word.gain_db == old_g_q) else $error("first subframe");
    sub_total_a: assert property ((state_q == ST_DONE) |-> push_cnt_q == nb_q) else $error("subframe total");
    old_store_a: assert property ((state_q == ST_DONE) |=>
        old_g_q == $past(frame_q.gmatch) && old_q[0] == $past(new_q[0])) else $error("previous values");

    long_frame_c: cover property (accept && FRAME.mode == MODE_LONG ##[1:60] state_q == ST_DONE);
    loss_frame_c: cover property (state_q == ST_DECODE && spec_loss_q);
    fifo_stall_c: cover property (state_q == ST_INTERP && !fifo_ready);
    superframe_c: cover property (accept && FRAME.mode == MODE_MEDIUM && pos_q == 2'd2);
endmodule
`default_nettype wire

// File: hfd_pkg.sv
// Shared constants and carrier types for the high-band parameter decoder
`default_nettype none
package hfd_pkg;
    localparam int ORDER          = 8;
    localparam int DW             = 16;
    localparam int SUPERFRAME_LEN = 1024;
    localparam int SUBFRAME_LEN   = 64;
    localparam int LEN_SHORT      = 256;
    localparam int LEN_MEDIUM     = 512;
    localparam int LEN_LONG       = 1024;
    localparam int NB_SHORT       = LEN_SHORT / SUBFRAME_LEN;
    localparam int NB_MEDIUM      = LEN_MEDIUM / SUBFRAME_LEN;
    localparam int NB_LONG        = LEN_LONG / SUBFRAME_LEN;
    localparam int QUARTERS       = SUPERFRAME_LEN / LEN_SHORT;
    localparam logic [1:0] MODE_MEDIUM = 2'h2;
    localparam logic [1:0] MODE_LONG   = 2'h3;
    // Prediction factor 0.5 is a shift, decay factor 0.9 is Q15
    localparam int MU_SHIFT             = 1;
    localparam int DECAY_FRAC           = 15;
    localparam logic signed [15:0] DECAY_Q = 16'sh7333;
    // Full scale 32768 stands for Fs/2; spacing 9*Fs/1280 rounded
    localparam int ISF_FULL_SCALE = 32768;
    localparam int GAP_NUM        = 9;
    localparam int GAP_DEN        = 1280;
    localparam int ISF_GAP        = (GAP_NUM * 2 * ISF_FULL_SCALE + GAP_DEN / 2) / GAP_DEN;
    localparam int FIFO_DEPTH     = 16;
    // Register map, byte addresses
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_COUNT  = 4'h8;
    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_CLRM_BIT = 1;
    localparam int CTRL_CLRA_BIT = 2;
    localparam logic CTRL_EN_RST = 1'b1;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_DECODE  = 3'b001,
        ST_REORDER = 3'b011,
        ST_INTERP  = 3'b010,
        ST_DONE    = 3'b110
    } hfd_state_t;

    typedef struct packed {
        logic [1:0]        mode;
        logic [3:0]        loss;
        logic [1:0]        idx1;
        logic [6:0]        idx2;
        logic signed [15:0] gmatch;
    } hfd_frame_t;

    typedef struct packed {
        logic [3:0]          sub;
        logic                last;
        logic                spec_loss;
        logic [3:0]          gain_loss;
        logic signed [15:0]  gain_db;
        logic [ORDER*DW-1:0] isp;
    } hfd_sub_t;

    function automatic logic [ORDER*DW-1:0] hfd_mean_default();
        logic [ORDER*DW-1:0] v;
        v = '0;
        for (int j = 0; j < ORDER; j++) begin
            v[j*DW +: DW] = DW'((j + 1) * (ISF_FULL_SCALE / (ORDER + 1)));
        end
        return v;
    endfunction
endpackage
`default_nettype wire

// File: hfd_demux_model.sv
// Frame source standing in for the demultiplexer
`default_nettype none
module hfd_demux_model
    import hfd_pkg::*;
(
    // Clock
    input  wire logic   clk,
    // Frame handshake
    input  wire logic   frame_ready,
    output var logic    frame_valid,
    output var hfd_frame_t frame
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        frame_valid = 1'b0;
        frame = '0;
    end
    // Offer holds until taken or until 3000 cycles pass; a released bus shows the inverse, never stale data
    task automatic send(input hfd_frame_t f, output bit ok);
        int n;
        @(posedge clk);
        frame_valid <= 1'b1;
        frame <= f;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (frame_ready !== 1'b1 && n < 3000);
        ok = (n < 3000);
        frame_valid <= 1'b0;
        frame <= ~f;
    endtask
endmodule
`default_nettype wire

// File: tb_hfd_decoder.sv
// Self-checking bench for the high-band parameter decoder
`default_nettype none
module tb_hfd_decoder
    import hfd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // Codevector 1 lifts every entry, codevector 2 pushes entry 0 under the gap
    function automatic logic [4*ORDER*DW-1:0] mk_cb1();
        logic [4*ORDER*DW-1:0] v;
        v = '0;
        for (int e = 0; e < ORDER; e++) begin
            v[(ORDER+e)*DW +: DW] = 16'h0064;
        end
        v[2*ORDER*DW +: DW] = 16'hf22c;
        return v;
    endfunction
    localparam logic [4*ORDER*DW-1:0] CB1V = mk_cb1();
    logic        clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, sub_ready = 0, hold = 0;
    logic [3:0]  reg_addr = '0;
    logic [31:0] reg_wdata = '0, reg_rdata;
    logic        frame_valid, frame_ready, sub_valid;
    hfd_frame_t  frame;
    hfd_sub_t    sub;
    hfd_sub_t    exp_q[$];
    int          error_cnt = 0, check_count = 0;
    int          mem[ORDER], old_isp[ORDER], old_g, pos, nfr;
    logic        last_sl;
    logic [3:0]  last_gl;
    logic [31:0] st_exp;

    hfd_decoder #(.CB1(CB1V)) dut (
        .CLOCK(clk), .ARST_N(arst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .FRAME_VALID(frame_valid), .FRAME_READY(frame_ready),
        .FRAME(frame), .SUB_VALID(sub_valid), .SUB_READY(sub_ready), .SUB(sub));
    hfd_demux_model src (.clk(clk), .frame_ready(frame_ready), .frame_valid(frame_valid), .frame(frame));

    initial begin
        forever #12.5 clk = ~clk;
    end

    function automatic int sat(input int v);
        return (v > 32767) ? 32767 : (v < -32768) ? -32768 : v;
    endfunction
    function automatic int mn(input int e);
        return (e + 1) * (ISF_FULL_SCALE / (ORDER + 1));
    endfunction

    task automatic check(input string what, input logic [159:0] exp, input logic [159:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Reference decode of one frame into its expected subframe words
    task automatic expect_frame(input hfd_frame_t f);
        int nb, sh, d, lo, r[ORDER];
        logic sl;
        logic [3:0] gl;
        hfd_sub_t s;
        nb = (f.mode <= 1) ? NB_SHORT : (f.mode == MODE_MEDIUM) ? NB_MEDIUM : NB_LONG;
        sh = (nb == 4) ? 2 : (nb == 8) ? 3 : 4;
        sl = (nb == NB_LONG) ? f.loss[0] : f.loss[pos];
        gl = (nb == NB_LONG) ? f.loss : (nb == NB_MEDIUM) ? {2'b0, f.loss[pos], f.loss[pos+1]} : {3'b0, f.loss[pos]};
        last_sl = sl;
        last_gl = gl;
        lo = ISF_GAP;
        for (int e = 0; e < ORDER; e++) begin
            d = sl ? sat(((mem[e] * 29491) >>> 15) + mn(e))
                   : sat($signed(CB1V[(f.idx1*ORDER+e)*DW +: DW]) + mn(e) + (mem[e] >>> 1));
            mem[e] = sat(d - mn(e));
            r[e] = (d < lo) ? sat(lo) : d;
            lo = r[e] + ISF_GAP;
        end
        for (int i = 0; i < nb; i++) begin
            s.sub = 4'(i);
            s.last = (i == nb - 1);
            s.spec_loss = sl;
            s.gain_loss = gl;
            s.gain_db = 16'(old_g + ((($signed(f.gmatch) - old_g) * i) >>> sh));
            for (int e = 0; e < ORDER; e++) begin
                s.isp[e*DW +: DW] = 16'(old_isp[e] + (((r[e] - old_isp[e]) * i) >>> sh));
            end
            exp_q.push_back(s);
        end
        old_isp = r;
        old_g = $signed(f.gmatch);
        pos = (pos + nb / 4) % 4;
        nfr++;
    endtask

    // Only aligned sizes: odd quarters take short frames, long frames start a superframe
    function automatic logic [1:0] pick_mode();
        logic [1:0] m;
        m = 2'($urandom);
        return (pos % 2) ? {1'b0, m[0]} : (pos == 2 && m == 2'h3) ? MODE_MEDIUM : m;
    endfunction

    task automatic run_frame(input logic [1:0] mode);
        hfd_frame_t f;
        bit ok;
        f = hfd_frame_t'({$urandom, $urandom});
        f.mode = mode;
        expect_frame(f);
        src.send(f, ok);
        check("frame taken", 1, ok);
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        check(what, exp, reg_rdata);
    endtask

    task automatic drain();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 5000) begin
            @(posedge clk);
            n++;
        end
        repeat (4) @(posedge clk);
        check("pending words", 0, exp_q.size());
    endtask

    task automatic do_reset();
        arst_n <= 1'b0;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        foreach (mem[e]) begin
            mem[e] = 0;
            old_isp[e] = 0;
        end
        old_g = 0;
        pos = 0;
        nfr = 0;
    endtask

    // Scoreboard side: the far end stalls at random or on demand
    always @(posedge clk) begin
        sub_ready <= hold ? 1'b0 : ($urandom % 4 != 0);
        if (arst_n && sub_valid === 1'b1 && sub_ready) begin
            if (exp_q.size() == 0) begin
                error_cnt++;
                $display("wrong value sub word expected none seen %h", sub);
            end else begin
                check("sub word", exp_q.pop_front(), sub);
            end
        end
    end

    task automatic close_out();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        close_out();
    end

    initial begin
        void'($urandom(32'h8acb));
        do_reset();
        reg_read(REG_CTRL, 32'h1, "ctrl");
        reg_read(4'hc, 32'h0, "unmapped");
        reg_write(4'hc, 32'hffffffff);
        for (int k = 0; k < 24; k++) begin
            run_frame(pick_mode());
        end
        drain();
        reg_read(REG_COUNT, 32'(nfr), "count");
        reg_write(REG_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        check("frame ready off", 0, frame_ready);
        reg_write(REG_CTRL, 32'h3);
        foreach (mem[e]) begin
            mem[e] = 0;
        end
        for (int k = 0; k < 6; k++) begin
            run_frame(pick_mode());
        end
        drain();
        // Second reset in mid-run, then fill the buffer with the far end stalled
        do_reset();
        hold <= 1'b1;
        run_frame(MODE_LONG);
        run_frame(2'h0);
        repeat (40) @(posedge clk);
        check("frame ready full", 0, frame_ready);
        check("sub valid full", 1, sub_valid);
        hold <= 1'b0;
        drain();
        // A medium frame at an odd quarter is flagged but still decoded
        run_frame(MODE_MEDIUM);
        drain();
        st_exp = {5'h0, 11'(LEN_MEDIUM), 5'(NB_MEDIUM), last_gl, last_sl, 1'b1, 2'd3, 3'd0};
        reg_read(REG_STATUS, st_exp, "status");
        reg_write(REG_CTRL, 32'h5);
        st_exp[5] = 1'b0;
        reg_read(REG_STATUS, st_exp, "status cleared");
        reg_read(REG_COUNT, 32'(nfr), "count after reset");
        close_out();
    end
endmodule
`default_nettype wire
